//--- rtl/fsf_pkg.sv
// package: constants and carriers for the fifo status flag block
package fsf_pkg;
   localparam int DEPTH = 256;
   localparam int DATA_W = 18;
   localparam int OFS_W = 12;
   localparam int ADDR_W = 8;
   localparam logic [11:0] EMPTY_OFS_RST = 12'h007;
   localparam logic [11:0] FULL_OFS_RST = 12'h007;
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_LEVEL = 8'h04;
   localparam logic [7:0] REG_EMPTY_OFS = 8'h08;
   localparam logic [7:0] REG_FULL_OFS = 8'h0C;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic {CFG_WAIT, CFG_HELD} fsf_cfg_state_t;
   typedef enum logic {OFS_EMPTY, OFS_FULL} fsf_ofs_sel_t;

   typedef struct packed {
      logic show_ahead;
      logic sync_flags;
      logic daisy;
   } fsf_cfg_t;

   // status register layout, bit 0 is full_out
   typedef struct packed {
      logic ofs_next_full;
      logic daisy;
      logic sync_flags;
      logic show_ahead;
      logic half_full_n;
      logic almost_empty_n;
      logic almost_full_n;
      logic empty_out;
      logic full_out;
   } fsf_status_t;

   typedef struct packed {
      logic valid;
      logic [7:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } fsf_regwr_t;
endpackage

//--- rtl/fsf_axil.sv
// module: axi4-lite slave front end for the fifo flag registers
`timescale 1ns/1ps
`default_nettype none
module fsf_axil (
   input wire logic aclk, // system clock
   input wire logic aresetn, // synchronous reset, active low
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   output fsf_pkg::fsf_regwr_t regwr, // register write command
   input wire logic wr_err, // write address not writable
   output logic [7:0] rd_addr, // aligned read address
   input wire logic [31:0] rd_data, // read value for rd_addr
   input wire logic rd_err // read address unmapped
);
   logic aw_held, next_aw_held, w_held, next_w_held;
   logic [7:0] waddr, next_waddr;
   logic [31:0] wdata, next_wdata;
   logic [3:0] wstrb, next_wstrb;
   logic next_bvalid, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_addr = {s_axi_araddr[7:2], 2'b00};
   assign regwr = '{valid: aw_held && w_held, addr: waddr, data: wdata, strb: wstrb};

   always_comb begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_waddr = waddr;
      next_wdata = wdata;
      next_wstrb = wstrb;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      next_rvalid = s_axi_rvalid;
      next_rresp = s_axi_rresp;
      next_rdata = s_axi_rdata;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_waddr = {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_wdata = s_axi_wdata;
         next_wstrb = s_axi_wstrb;
      end
      if (aw_held && w_held) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = wr_err ? fsf_pkg::RESP_SLVERR : fsf_pkg::RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rdata = rd_data;
         next_rresp = rd_err ? fsf_pkg::RESP_SLVERR : fsf_pkg::RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         waddr <= 8'h00;
         wdata <= 32'h0000_0000;
         wstrb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= fsf_pkg::RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= fsf_pkg::RESP_OKAY;
         s_axi_rdata <= 32'h0000_0000;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         waddr <= next_waddr;
         wdata <= next_wdata;
         wstrb <= next_wstrb;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rresp <= next_rresp;
         s_axi_rdata <= next_rdata;
      end
   end
endmodule
`default_nettype wire

//--- rtl/fsf_flags.sv
// module: status flags, chain pulses and offsets of one fifo channel
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module fsf_flags #(
   parameter int DEPTH = fsf_pkg::DEPTH,
   parameter int DATA_W = fsf_pkg::DATA_W,
   parameter int OFS_W = fsf_pkg::OFS_W
) (
   input wire logic aclk, // system clock
   input wire logic aresetn, // synchronous reset, active low
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic wr_tick, // write side clock edge enable
   input wire logic rd_tick, // read side clock edge enable
   input wire logic wr_req, // write strobe, high to write
   input wire logic rd_req, // read strobe, high to read
   input wire logic offset_load_n, // low routes writes to offsets
   input wire logic [OFS_W-1:0] offset_data, // offset value to load
   input wire logic first_load_sel, // mode pin, sampled at reset
   input wire logic read_chain_in, // mode pin, sampled at reset
   input wire logic write_chain_in, // mode pin, sampled at reset
   input wire logic output_drive_n, // data output enable pin, low drives
   input wire logic [DATA_W-1:0] ram_rdata, // ram word at ram_raddr
   output logic [$clog2(DEPTH)-1:0] ram_waddr, // ram write address
   output logic ram_we, // ram write strobe
   output logic [$clog2(DEPTH)-1:0] ram_raddr, // ram read address
   output logic [DATA_W-1:0] read_data_out, // output data register
   output logic read_data_oe, // output enable of read_data_out
   output logic full_ready_n, // full flag or input ready
   output logic empty_ready_n, // empty flag or output ready
   output logic almost_full_n, // programmable almost full
   output logic almost_empty_n, // programmable almost empty
   output logic write_chain_out, // half full or write chain pulse
   output logic read_chain_out // read chain pulse
);
   localparam int MW = $clog2(DEPTH + 1);
   localparam int PW = $clog2(DEPTH);
   localparam int XW = OFS_W + 2;

   function automatic logic [OFS_W-1:0] merge(input logic [OFS_W-1:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
      logic [31:0] w;
      w = 32'(old);
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            w[8*i +: 8] = data[8*i +: 8];
         end
      end
      return w[OFS_W-1:0];
   endfunction

   fsf_pkg::fsf_regwr_t regwr;
   logic wr_err, rd_err;
   logic [7:0] rd_addr;
   logic [31:0] rd_data;

   fsf_axil u_axil (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .regwr(regwr),
      .wr_err(wr_err),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and mode capture
   logic [3:0] pin_s1, pin_s2;
   fsf_pkg::fsf_cfg_state_t cfg_state, next_cfg_state;
   fsf_pkg::fsf_cfg_t cfg, next_cfg;
   logic run;

   always_ff @(posedge aclk) begin
      pin_s1 <= {output_drive_n, first_load_sel, read_chain_in, write_chain_in};
      pin_s2 <= pin_s1;
   end

   always_comb begin
      next_cfg_state = cfg_state;
      next_cfg = cfg;
      case (cfg_state)
         fsf_pkg::CFG_WAIT: begin
            next_cfg.show_ahead = !pin_s2[1] && pin_s2[0];
            next_cfg.daisy = pin_s2[1] && pin_s2[0];
            next_cfg.sync_flags = pin_s2[2] && !(pin_s2[1] && pin_s2[0]);
            next_cfg_state = fsf_pkg::CFG_HELD;
         end
         fsf_pkg::CFG_HELD: next_cfg_state = fsf_pkg::CFG_HELD;
         default: next_cfg_state = fsf_pkg::CFG_WAIT;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_state <= fsf_pkg::CFG_WAIT;
         cfg <= '0;
      end else begin
         cfg_state <= next_cfg_state;
         cfg <= next_cfg;
      end
   end

   assign run = cfg_state == fsf_pkg::CFG_HELD;
   assign read_data_oe = !pin_s2[3];

   ////////////////////////////////////////////////////////////////////////////////
   // word counts, pointers and output register
   logic [MW-1:0] mem_cnt, next_mem;
   logic [PW-1:0] wptr, next_wptr, rptr, next_rptr;
   logic out_valid, next_out_valid, has_data, next_has_data;
   logic [DATA_W-1:0] next_rdata;
   logic [MW:0] next_level, cur_level;
   logic wr_ok, rd_ok, ld, full_n;
   logic wco_pulse, next_wco, rco_pulse, next_rco;

   always_comb begin
      wr_ok = run && wr_tick && wr_req && offset_load_n && full_n;
      if (cfg.show_ahead) begin
         rd_ok = run && rd_tick && rd_req && out_valid;
         ld = run && rd_tick && (mem_cnt != '0) && (!out_valid || rd_req);
      end else begin
         rd_ok = run && rd_tick && rd_req && has_data;
         ld = rd_ok;
      end
      case ({wr_ok, ld})
         2'b10: next_mem = mem_cnt + 1'b1;
         2'b01: next_mem = mem_cnt - 1'b1;
         default: next_mem = mem_cnt;
      endcase
      next_wptr = wr_ok ? wptr + 1'b1 : wptr;
      next_rptr = ld ? rptr + 1'b1 : rptr;
      next_out_valid = out_valid;
      if (ld) begin
         next_out_valid = 1'b1;
      end else if (rd_ok) begin
         next_out_valid = 1'b0;
      end
      next_has_data = has_data;
      if (rd_tick) begin
         next_has_data = next_mem != '0;
      end
      next_rdata = ld ? ram_rdata : read_data_out;
      next_wco = cfg.daisy && wr_ok && (wptr == PW'(DEPTH - 1));
      next_rco = cfg.daisy && ld && (rptr == PW'(DEPTH - 1));
      next_level = {1'b0, next_mem} + (MW + 1)'(cfg.show_ahead && next_out_valid);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mem_cnt <= '0;
         wptr <= '0;
         rptr <= '0;
         out_valid <= 1'b0;
         has_data <= 1'b0;
         read_data_out <= '0;
         wco_pulse <= 1'b0;
         rco_pulse <= 1'b0;
      end else begin
         mem_cnt <= next_mem;
         wptr <= next_wptr;
         rptr <= next_rptr;
         out_valid <= next_out_valid;
         has_data <= next_has_data;
         read_data_out <= next_rdata;
         wco_pulse <= next_wco;
         rco_pulse <= next_rco;
      end
   end

   assign cur_level = {1'b0, mem_cnt} + (MW + 1)'(cfg.show_ahead && out_valid);
   assign ram_waddr = wptr;
   assign ram_raddr = rptr;
   assign ram_we = wr_ok;

   ////////////////////////////////////////////////////////////////////////////////
   // offset registers
   fsf_pkg::fsf_ofs_sel_t osel, next_osel;
   logic [OFS_W-1:0] empty_ofs, next_eofs, full_ofs, next_fofs;

   always_comb begin
      next_osel = osel;
      next_eofs = empty_ofs;
      next_fofs = full_ofs;
      if (run && wr_tick && wr_req && !offset_load_n) begin
         case (osel)
            fsf_pkg::OFS_EMPTY: begin
               next_eofs = offset_data;
               next_osel = fsf_pkg::OFS_FULL;
            end
            fsf_pkg::OFS_FULL: begin
               next_fofs = offset_data;
               next_osel = fsf_pkg::OFS_EMPTY;
            end
            default: next_osel = fsf_pkg::OFS_EMPTY;
         endcase
      end else if (regwr.valid && regwr.addr == fsf_pkg::REG_EMPTY_OFS) begin
         next_eofs = merge(empty_ofs, regwr.data, regwr.strb);
      end else if (regwr.valid && regwr.addr == fsf_pkg::REG_FULL_OFS) begin
         next_fofs = merge(full_ofs, regwr.data, regwr.strb);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osel <= fsf_pkg::OFS_EMPTY;
         empty_ofs <= OFS_W'(fsf_pkg::EMPTY_OFS_RST);
         full_ofs <= OFS_W'(fsf_pkg::FULL_OFS_RST);
      end else begin
         osel <= next_osel;
         empty_ofs <= next_eofs;
         full_ofs <= next_fofs;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // full, almost full, almost empty and half full flags
   logic next_full_n, af_n, next_af_n, ae_n, next_ae_n, hf_n, next_hf_n;
   logic [XW-1:0] lvl, cap;
   logic af_hit, ae_hit, hf_hit;

   always_comb begin
      lvl = XW'(next_level);
      cap = cfg.show_ahead ? XW'(DEPTH + 1) : XW'(DEPTH);
      af_hit = (lvl + XW'(full_ofs)) >= cap;
      ae_hit = lvl <= (XW'(empty_ofs) + XW'(cfg.show_ahead));
      hf_hit = XW'(next_mem) > XW'(DEPTH / 2);
      next_full_n = full_n;
      next_af_n = af_n;
      next_ae_n = ae_n;
      next_hf_n = hf_n;
      // a read in the same cycle already counts, so no extra edge of delay
      if (wr_tick) begin
         next_full_n = lvl < cap;
      end
      if (cfg.sync_flags) begin
         if (wr_tick) begin
            next_af_n = !af_hit;
         end
         if (rd_tick) begin
            next_ae_n = !ae_hit;
         end
      end else begin
         if (wr_tick && af_hit) begin
            next_af_n = 1'b0;
         end else if (rd_tick && !af_hit) begin
            next_af_n = 1'b1;
         end
         if (rd_tick && ae_hit) begin
            next_ae_n = 1'b0;
         end else if (wr_tick && !ae_hit) begin
            next_ae_n = 1'b1;
         end
      end
      if (wr_tick && hf_hit) begin
         next_hf_n = 1'b0;
      end else if (rd_tick && !hf_hit) begin
         next_hf_n = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         full_n <= 1'b1;
         af_n <= 1'b1;
         ae_n <= 1'b0;
         hf_n <= 1'b1;
      end else begin
         full_n <= next_full_n;
         af_n <= next_af_n;
         ae_n <= next_ae_n;
         hf_n <= next_hf_n;
      end
   end

   assign full_ready_n = cfg.show_ahead ? !full_n : full_n;
   assign empty_ready_n = cfg.show_ahead ? !out_valid : has_data;
   assign almost_full_n = af_n;
   assign almost_empty_n = ae_n;
   assign write_chain_out = cfg.daisy ? !wco_pulse : hf_n;
   assign read_chain_out = !rco_pulse;

   ////////////////////////////////////////////////////////////////////////////////
   // register read decode
   fsf_pkg::fsf_status_t status;

   assign status = '{ofs_next_full: osel == fsf_pkg::OFS_FULL, daisy: cfg.daisy,
                     sync_flags: cfg.sync_flags, show_ahead: cfg.show_ahead,
                     half_full_n: hf_n, almost_empty_n: ae_n, almost_full_n: af_n,
                     empty_out: empty_ready_n, full_out: full_ready_n};
   assign wr_err = !(regwr.addr == fsf_pkg::REG_EMPTY_OFS
                     || regwr.addr == fsf_pkg::REG_FULL_OFS);

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_err = 1'b0;
      case (rd_addr)
         fsf_pkg::REG_STATUS: rd_data = 32'(status);
         fsf_pkg::REG_LEVEL: rd_data = 32'(cur_level);
         fsf_pkg::REG_EMPTY_OFS: rd_data = 32'(empty_ofs);
         fsf_pkg::REG_FULL_OFS: rd_data = 32'(full_ofs);
         default: rd_err = 1'b1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   full_edge_a: assert property ($changed(full_n) |-> $past(wr_tick))
      else $error("full flag moved without write edge");
   empty_edge_a: assert property (($changed(has_data) || $changed(out_valid))
      |-> $past(rd_tick)) else $error("empty flag moved without read edge");
   full_depth_a: assert property ((!cfg.show_ahead && wr_ok && !ld
      && mem_cnt == MW'(DEPTH - 1)) |=> !full_ready_n)
      else $error("full flag not low at depth");
   full_hold_a: assert property ((!cfg.show_ahead && mem_cnt == MW'(DEPTH))
      |-> !full_ready_n) else $error("full flag high while full");
   ready_depth_a: assert property ((cfg.show_ahead && wr_ok && !ld && out_valid
      && mem_cnt == MW'(DEPTH - 1)) |=> full_ready_n ##0 cur_level == (MW + 1)'(DEPTH + 1))
      else $error("input ready not high at depth plus one");
   last_word_a: assert property ((cfg.show_ahead && rd_ok && mem_cnt == '0)
      |=> empty_ready_n && $stable(read_data_out))
      else $error("last word not held after true read");
   af_async_a: assert property ((!cfg.sync_flags && run && $rose(almost_full_n))
      |-> $past(rd_tick)) else $error("async almost full released off read edge");
   af_sync_a: assert property ((cfg.sync_flags && $changed(almost_full_n))
      |-> $past(wr_tick)) else $error("sync almost full moved off write edge");
   ae_sync_a: assert property ((cfg.sync_flags && $changed(almost_empty_n))
      |-> $past(rd_tick)) else $error("sync almost empty moved off read edge");
   hf_set_a: assert property ($fell(hf_n)
      |-> $past(wr_tick) && mem_cnt > MW'(DEPTH / 2))
      else $error("half full set wrongly");
   chain_pulse_a: assert property ((cfg.daisy && wr_ok && wptr == PW'(DEPTH - 1))
      |=> !write_chain_out ##1 write_chain_out) else $error("write chain pulse wrong");
   ofs_alt_a: assert property ((run && wr_tick && wr_req && !offset_load_n
      && osel == fsf_pkg::OFS_EMPTY) |=> empty_ofs == $past(offset_data)
      && osel == fsf_pkg::OFS_FULL) else $error("offset load order wrong");
   reset_flags_a: assert property ($rose(aresetn) |-> almost_full_n
      && !almost_empty_n && full_ready_n && write_chain_out && !empty_ready_n
      && read_data_out == '0) else $error("flag reset values wrong");

   full_reach_c: cover property (!cfg.show_ahead && !full_ready_n);
   ready_last_c: cover property (cfg.show_ahead && rd_ok && mem_cnt == '0);
   chain_c: cover property (cfg.daisy && !write_chain_out);
   reg_write_c: cover property (regwr.valid && !wr_err);
endmodule
`default_nettype wire

//--- verification/fsf_ram_model.sv
// memory model standing behind the flag block
`timescale 1ns/1ps
`default_nettype none
module fsf_ram_model (
   input wire logic aclk, // system clock
   input wire logic ram_we, // write strobe
   input wire logic [7:0] ram_waddr, // write address
   input wire logic [7:0] ram_raddr, // read address
   output logic [17:0] ram_rdata // word at read address
);
   logic [17:0] mem [256];
   // each word carries its own address so the read order can be seen
   always_ff @(posedge aclk) begin
      if (ram_we) begin
         mem[ram_waddr] <= {10'h2A5, ram_waddr};
      end
   end
   assign ram_rdata = mem[ram_raddr];
endmodule
`default_nettype wire

//--- verification/test_fsf_flags.sv
// self-checking bench for the fifo status flag block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
   $display("mismatch at %0t: %h vs %h", $time, (a), (e)); end end
module test_fsf_flags;
   typedef struct packed {logic we; logic [7:0] a; logic [31:0] d; logic [1:0] r;} fsf_row_t;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, wr_tick = 0, rd_tick = 0, wr_req = 0, rd_req = 0;
   logic offset_load_n = 1, first_load_sel = 0, read_chain_in = 0, write_chain_in = 0;
   logic output_drive_n = 0, ram_we, read_data_oe, full_ready_n, empty_ready_n, almost_full_n;
   logic almost_empty_n, write_chain_out, read_chain_out, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, ram_waddr, ram_raddr;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, q;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [11:0] offset_data = 12'h000;
   logic [17:0] ram_rdata, read_data_out;
   int error_cnt = 0, n_checks = 0, k;
   fsf_row_t rows [7] = '{'{0, 8'h00, 32'h15, 2'h0}, '{0, 8'h04, 32'h0, 2'h0},
      '{0, 8'h08, 32'h7, 2'h0}, '{1, 8'h08, 32'h9, 2'h0}, '{0, 8'h08, 32'h9, 2'h0},
      '{1, 8'h00, 32'h0, 2'h2}, '{0, 8'h10, 32'h0, 2'h2}};
   fsf_flags dut (.*);
   fsf_ram_model ram (.*);
   always #2.5 aclk = ~aclk;
   task final_report;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task rst;
      @(posedge aclk) aresetn <= 0;
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      repeat (2) @(posedge aclk);
   endtask
   task tk(input logic wt, input logic w, input logic rt, input logic rq);
      @(posedge aclk);
      wr_tick <= wt; wr_req <= w; rd_tick <= rt; rd_req <= rq;
      @(posedge aclk);
      wr_tick <= 0; rd_tick <= 0;
      #1;
   endtask
   // one write or one read, answer sampled where it is settled
   task axi(input logic we, input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_araddr <= a; s_axi_wdata <= d;
      s_axi_awvalid <= we; s_axi_wvalid <= we; s_axi_bready <= we;
      s_axi_arvalid <= !we; s_axi_rready <= !we;
      do begin
         @(negedge aclk);
         ta = we ? s_axi_awready : s_axi_arready;
         tw = s_axi_wready;
         tb = we ? s_axi_bvalid : s_axi_rvalid;
         r = we ? s_axi_bresp : s_axi_rresp;
         q = s_axi_rdata;
         @(posedge aclk);
         if (ta) begin s_axi_awvalid <= 0; s_axi_arvalid <= 0; end
         if (tw) s_axi_wvalid <= 0;
      end while (!tb);
      s_axi_bready <= 0;
      s_axi_rready <= 0;
   endtask
   initial begin
      #40000;
      error_cnt++;
      final_report;
   end
   initial begin
      rst;
      #1 `CHK(read_data_out, 18'h0)
      `CHK(read_data_oe, 1'b1)
      foreach (rows[i]) begin
         axi(rows[i].we, rows[i].a, rows[i].d);
         `CHK(r, rows[i].r)
         if (!rows[i].we) `CHK(q, rows[i].d)
      end
      for (k = 1; k <= 257; k++) begin
         tk(1, 1, 0, 0);
         `CHK(full_ready_n, k < 256)
         `CHK(almost_full_n, k < 249)
         `CHK(write_chain_out, k <= 128)
         `CHK(almost_empty_n, k > 9)
      end
      `CHK(empty_ready_n, 1'b0)
      tk(0, 0, 1, 0);
      `CHK(empty_ready_n, 1'b1)
      axi(0, 8'h04, 0);
      `CHK(q, 32'h100)
      tk(0, 0, 1, 1);
      `CHK(full_ready_n, 1'b0)
      for (k = 254; k >= 0; k--) begin
         tk(1, 0, 1, 1);
         `CHK(read_data_out, {10'h2A5, 8'(255 - k)})
         `CHK(full_ready_n, 1'b1)
         `CHK(almost_full_n, k < 249)
         `CHK(write_chain_out, k <= 128)
         `CHK(almost_empty_n, k > 9)
         `CHK(empty_ready_n, k > 0)
      end
      tk(1, 0, 1, 1);
      `CHK(read_data_out, {10'h2A5, 8'hFF})
      @(posedge aclk) output_drive_n <= 1;
      repeat (4) @(posedge aclk);
      #1 `CHK(read_data_oe, 1'b0)
      write_chain_in <= 1;
      rst;
      tk(1, 1, 0, 0);
      `CHK(empty_ready_n, 1'b1)
      tk(0, 0, 1, 0);
      `CHK(empty_ready_n, 1'b0)
      `CHK(read_data_out, {10'h2A5, 8'h00})
      for (k = 2; k <= 257; k++) begin
         tk(1, 1, 0, 0);
         `CHK(full_ready_n, k == 257)
         `CHK(almost_full_n, k < 250)
      end
      // drain in show-ahead: the last word stays once output ready rises
      for (k = 1; k <= 258; k++) begin
         tk(0, 0, 1, 1);
         `CHK(read_data_out, {10'h2A5, 8'(k > 256 ? 0 : k)})
         `CHK(empty_ready_n, k > 256)
         `CHK(almost_empty_n, k < 249)
         `CHK(full_ready_n, 1'b1)
      end
      first_load_sel <= 1;
      write_chain_in <= 0;
      rst;
      offset_load_n <= 0;
      offset_data <= 12'h003;
      tk(1, 1, 0, 0);
      offset_data <= 12'h005;
      tk(1, 1, 0, 0);
      offset_load_n <= 1;
      axi(0, 8'h08, 0);
      `CHK(q, 32'h3)
      axi(0, 8'h0C, 0);
      `CHK(q, 32'h5)
      for (k = 1; k <= 256; k++) begin
         tk(1, 1, 0, 0);
         `CHK(almost_full_n, k < 251)
         `CHK(almost_empty_n, 1'b0)
      end
      tk(0, 0, 1, 1);
      `CHK(almost_empty_n, 1'b1)
      repeat (10) tk(0, 0, 1, 1);
      `CHK(almost_full_n, 1'b0)
      tk(1, 0, 0, 0);
      `CHK(almost_full_n, 1'b1)
      read_chain_in <= 1;
      write_chain_in <= 1;
      rst;
      for (k = 1; k <= 256; k++) begin
         tk(1, 1, 0, 0);
         `CHK(write_chain_out, k != 256)
      end
      tk(0, 0, 1, 0);
      for (k = 1; k <= 256; k++) begin
         tk(0, 0, 1, 1);
         `CHK(read_chain_out, k != 256)
      end
      final_report;
   end
endmodule
`default_nettype wire
